// [core/secondary_timer_pkg.sv]
// Constants, types and register map of the secondary watchdog block.
// Assumes a 100 MHz bus clock and a 32.768 kHz reference level sampled on it.
package secondary_timer_pkg;

    // ========================================================================
    // Bus and register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_TCONST = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN = 8'h18;
    localparam logic [7:0] OFF_STATE = 8'h1C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================================
    // Interrupt status layout and state register fields
    localparam int IRQ_W = 2;
    localparam int IRQ_SEC_BIT = 0;
    localparam int IRQ_PRI_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 2'h0;
    localparam int ST_COUNT_LSB = 0;
    localparam int ST_ACTIVE_LSB = 8;
    localparam int ST_RUN_BIT = 16;
    localparam int ST_PEND_LSB = 24;
    localparam logic [7:0] TCONST_RESET = 8'h00;
    localparam logic [1:0] SEC_PRIORITY = 2'h3;

    // ========================================================================
    // Command codes
    localparam logic [7:0] CMD_PRI_2S = 8'h5A;
    localparam logic [7:0] CMD_PRI_1S = 8'h57;
    localparam logic [7:0] CMD_PRI_500MS = 8'h59;
    localparam logic [7:0] CMD_PRI_250MS = 8'h53;
    localparam logic [7:0] CMD_SEC_RESTART = 8'h5F;
    localparam logic [7:0] SEQ_BYTE1 = 8'h5A;
    localparam logic [7:0] SEQ_BYTE2 = 8'h52;
    localparam logic [7:0] SEQ_BYTE3 = 8'h44;

    // ========================================================================
    // Timing: reference rate and primary periods in reference ticks
    localparam int REF_HZ = 32768;
    localparam int PRI_2S_MS = 2000;
    localparam int PRI_1S_MS = 1000;
    localparam int PRI_500_MS = 500;
    localparam int PRI_250_MS = 250;
    localparam int PRI_W = 17;
    localparam int PRI_2S_TICKS = PRI_2S_MS * REF_HZ / 1000;
    localparam int PRI_1S_TICKS = PRI_1S_MS * REF_HZ / 1000;
    localparam int PRI_500_TICKS = PRI_500_MS * REF_HZ / 1000;
    localparam int PRI_250_TICKS = PRI_250_MS * REF_HZ / 1000;

    typedef enum logic [1:0] {
        SECONDARY_TIMER_SEQ_IDLE = 2'b00,
        SECONDARY_TIMER_SEQ_GOT1 = 2'b01,
        SECONDARY_TIMER_SEQ_GOT2 = 2'b11
    } secondary_timer_seq_t;

    typedef struct packed {
        logic stop;
        logic restart;
        logic tc_wr;
        logic [7:0] tc;
    } secondary_timer_ctl_t;

    typedef struct packed {
        logic running;
        logic expire;
        logic [7:0] count;
        logic [7:0] active;
        logic [7:0] pend;
    } secondary_timer_stat_t;

endpackage

// [core/secondary_timer_counter.sv]
// Secondary down counter: runs on reference ticks, reloads at zero.
// Assumes control pulses last one bus cycle and stop and restart are never set together.
`timescale 1ns/100ps
module secondary_timer_counter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire secondary_timer_pkg::secondary_timer_ctl_t ctl,
    output secondary_timer_pkg::secondary_timer_stat_t st
);

    logic running_r;
    logic expire_r;
    logic [7:0] count_r;
    logic [7:0] active_r;
    logic [7:0] pend_r;

    assign st = '{running: running_r, expire: expire_r, count: count_r, active: active_r, pend: pend_r};

    // ========================================================================
    // Held time constant
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_r <= secondary_timer_pkg::TCONST_RESET;
        end else if (ctl.tc_wr) begin
            pend_r <= ctl.tc;
        end
    end

    // ========================================================================
    // Countdown
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            running_r <= 1'b0;
            count_r <= secondary_timer_pkg::TCONST_RESET;
            active_r <= secondary_timer_pkg::TCONST_RESET;
            expire_r <= 1'b0;
        end else begin
            expire_r <= 1'b0;
            if (ctl.stop) begin
                running_r <= 1'b0;
            end else if (ctl.restart) begin
                running_r <= 1'b1;
                if (running_r) begin
                    count_r <= active_r;
                end else begin
                    count_r <= pend_r;
                    active_r <= pend_r;
                end
            end else if (tick && running_r) begin
                if (count_r == 8'h00) begin
                    // Expiry reloads, so the timer doubles as a periodic source.
                    expire_r <= 1'b1;
                    count_r <= pend_r;
                    active_r <= pend_r;
                end else begin
                    count_r <= count_r - 8'h01;
                end
            end
        end
    end

    // ========================================================================
    // Checks
    property p_count_down;
        @(posedge aclk) disable iff (!aresetn)
        (tick && running_r && !ctl.stop && !ctl.restart && count_r != 8'h00) |=> count_r == $past(count_r) - 8'h01;
    endproperty
    a_count_down: assert property (p_count_down) else $error("Counter did not step down on a tick.");

    property p_periodic;
        @(posedge aclk) disable iff (!aresetn)
        expire_r |-> running_r && count_r == active_r;
    endproperty
    a_periodic: assert property (p_periodic) else $error("Counter did not reload after expiry.");

    property p_hold_const;
        @(posedge aclk) disable iff (!aresetn)
        (ctl.tc_wr && !tick && !ctl.restart) |=> active_r == $past(active_r) && count_r == $past(count_r);
    endproperty
    a_hold_const: assert property (p_hold_const) else $error("New time constant took effect early.");

endmodule

// [core/secondary_timer_top.sv]
// Secondary watchdog with primary restart codes, behind an AXI4-Lite slave.
// Assumes ref_clk_in is a level already synchronous to aclk.
`timescale 1ns/100ps

module secondary_timer_top #(
    parameter int PRI_TICKS_2S = secondary_timer_pkg::PRI_2S_TICKS,
    parameter int PRI_TICKS_1S = secondary_timer_pkg::PRI_1S_TICKS,
    parameter int PRI_TICKS_500MS = secondary_timer_pkg::PRI_500_TICKS,
    parameter int PRI_TICKS_250MS = secondary_timer_pkg::PRI_250_TICKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ref_clk_in,
    input wire logic [secondary_timer_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [secondary_timer_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [secondary_timer_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [secondary_timer_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    output logic [1:0] irq_priority,
    output logic primary_expired
);

    localparam logic [secondary_timer_pkg::PRI_W-1:0] PRI_2S = secondary_timer_pkg::PRI_W'(PRI_TICKS_2S - 1);
    localparam logic [secondary_timer_pkg::PRI_W-1:0] PRI_1S = secondary_timer_pkg::PRI_W'(PRI_TICKS_1S - 1);
    localparam logic [secondary_timer_pkg::PRI_W-1:0] PRI_500 = secondary_timer_pkg::PRI_W'(PRI_TICKS_500MS - 1);
    localparam logic [secondary_timer_pkg::PRI_W-1:0] PRI_250 = secondary_timer_pkg::PRI_W'(PRI_TICKS_250MS - 1);

    function automatic logic is_mapped(input logic [secondary_timer_pkg::ADDR_W-1:0] a);
        is_mapped = (a == secondary_timer_pkg::OFF_CMD) || (a == secondary_timer_pkg::OFF_TCONST) ||
                    (a == secondary_timer_pkg::OFF_IRQ_STAT) || (a == secondary_timer_pkg::OFF_IRQ_CLR) ||
                    (a == secondary_timer_pkg::OFF_IRQ_EN) || (a == secondary_timer_pkg::OFF_STATE);
    endfunction

    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [secondary_timer_pkg::DATA_W-1:0] rdata_r;
    logic aw_held_r;
    logic w_held_r;
    logic [secondary_timer_pkg::ADDR_W-1:0] waddr_r;
    logic [7:0] wbyte_r;
    logic wlane0_r;
    logic ref_prev_r;
    logic [secondary_timer_pkg::IRQ_W-1:0] irq_stat_r;
    logic [secondary_timer_pkg::IRQ_W-1:0] irq_en_r;
    logic irq_r;
    logic [secondary_timer_pkg::PRI_W-1:0] pri_cnt_r;
    logic [secondary_timer_pkg::PRI_W-1:0] pri_period_r;
    logic pri_exp_r;
    secondary_timer_pkg::secondary_timer_seq_t seq_r;
    secondary_timer_pkg::secondary_timer_seq_t seq_nxt;

    logic do_wr;
    logic cmd_wr;
    logic tc_wr;
    logic tick;
    logic seq_done;
    logic [secondary_timer_pkg::IRQ_W-1:0] irq_set;
    secondary_timer_pkg::secondary_timer_ctl_t ctl;
    secondary_timer_pkg::secondary_timer_stat_t sec;

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign irq = irq_r;
    assign primary_expired = pri_exp_r;

    // ========================================================================
    // Write channel: address and data are taken in either order.
    assign do_wr = aw_held_r && w_held_r && !bvalid_r;
    // A write without the low byte lane carries no byte and has no effect.
    assign cmd_wr = do_wr && wlane0_r && waddr_r == secondary_timer_pkg::OFF_CMD;
    assign tc_wr = do_wr && wlane0_r && waddr_r == secondary_timer_pkg::OFF_TCONST;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            aw_held_r <= 1'b0;
            waddr_r <= '0;
        end else if (awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b1;
            waddr_r <= awaddr;
        end else if (bvalid_r && bready) begin
            awready_r <= 1'b1;
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_r <= 1'b1;
            w_held_r <= 1'b0;
            wbyte_r <= 8'h00;
            wlane0_r <= 1'b0;
        end else if (wvalid && wready_r) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b1;
            wbyte_r <= wdata[7:0];
            wlane0_r <= wstrb[0];
        end else if (bvalid_r && bready) begin
            wready_r <= 1'b1;
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= secondary_timer_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r <= is_mapped(waddr_r) ? secondary_timer_pkg::RESP_OKAY : secondary_timer_pkg::RESP_SLVERR;
        end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ========================================================================
    // Read channel: write-only registers read as zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= secondary_timer_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= is_mapped(araddr) ? secondary_timer_pkg::RESP_OKAY : secondary_timer_pkg::RESP_SLVERR;
            rdata_r <= '0;
            case (araddr)
                secondary_timer_pkg::OFF_IRQ_STAT: begin
                    rdata_r[secondary_timer_pkg::IRQ_W-1:0] <= irq_stat_r;
                end
                secondary_timer_pkg::OFF_IRQ_EN: begin
                    rdata_r[secondary_timer_pkg::IRQ_W-1:0] <= irq_en_r;
                end
                secondary_timer_pkg::OFF_STATE: begin
                    rdata_r[secondary_timer_pkg::ST_COUNT_LSB +: 8] <= sec.count;
                    rdata_r[secondary_timer_pkg::ST_ACTIVE_LSB +: 8] <= sec.active;
                    rdata_r[secondary_timer_pkg::ST_RUN_BIT] <= sec.running;
                    rdata_r[secondary_timer_pkg::ST_PEND_LSB +: 8] <= sec.pend;
                end
                default: begin
                    rdata_r <= '0;
                end
            endcase
        end else if (rvalid_r && rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // ========================================================================
    // Reference tick: one bus cycle per rising edge of the 32.768 kHz level.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_prev_r <= 1'b0;
        end else begin
            ref_prev_r <= ref_clk_in;
        end
    end
    assign tick = ref_clk_in && !ref_prev_r;

    // ========================================================================
    // Stop sequence on the timeout register.
    always_comb begin
        seq_nxt = seq_r;
        if (tc_wr) begin
            case (seq_r)
                secondary_timer_pkg::SECONDARY_TIMER_SEQ_IDLE: begin
                    seq_nxt = (wbyte_r == secondary_timer_pkg::SEQ_BYTE1) ? secondary_timer_pkg::SECONDARY_TIMER_SEQ_GOT1 : secondary_timer_pkg::SECONDARY_TIMER_SEQ_IDLE;
                end
                secondary_timer_pkg::SECONDARY_TIMER_SEQ_GOT1: begin
                    if (wbyte_r == secondary_timer_pkg::SEQ_BYTE2) begin
                        seq_nxt = secondary_timer_pkg::SECONDARY_TIMER_SEQ_GOT2;
                    end else begin
                        seq_nxt = (wbyte_r == secondary_timer_pkg::SEQ_BYTE1) ? secondary_timer_pkg::SECONDARY_TIMER_SEQ_GOT1 : secondary_timer_pkg::SECONDARY_TIMER_SEQ_IDLE;
                    end
                end
                secondary_timer_pkg::SECONDARY_TIMER_SEQ_GOT2: begin
                    seq_nxt = (wbyte_r == secondary_timer_pkg::SEQ_BYTE1) ? secondary_timer_pkg::SECONDARY_TIMER_SEQ_GOT1 : secondary_timer_pkg::SECONDARY_TIMER_SEQ_IDLE;
                end
                default: begin
                    seq_nxt = secondary_timer_pkg::SECONDARY_TIMER_SEQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_r <= secondary_timer_pkg::SECONDARY_TIMER_SEQ_IDLE;
        end else begin
            seq_r <= seq_nxt;
        end
    end

    assign seq_done = tc_wr && seq_r == secondary_timer_pkg::SECONDARY_TIMER_SEQ_GOT2 && wbyte_r == secondary_timer_pkg::SEQ_BYTE3;

    // Every timeout byte, sequence bytes included, also becomes the held constant.
    assign ctl = '{stop: seq_done, restart: cmd_wr && wbyte_r == secondary_timer_pkg::CMD_SEC_RESTART,
                   tc_wr: tc_wr, tc: wbyte_r};

    secondary_timer_counter i_secondary_timer_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .ctl(ctl),
        .st(sec)
    );

    // ========================================================================
    // Primary watchdog: runs from reset with the longest period.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pri_cnt_r <= PRI_2S;
            pri_period_r <= PRI_2S;
            pri_exp_r <= 1'b0;
        end else begin
            pri_exp_r <= 1'b0;
            if (cmd_wr && wbyte_r == secondary_timer_pkg::CMD_PRI_2S) begin
                pri_cnt_r <= PRI_2S;
                pri_period_r <= PRI_2S;
            end else if (cmd_wr && wbyte_r == secondary_timer_pkg::CMD_PRI_1S) begin
                pri_cnt_r <= PRI_1S;
                pri_period_r <= PRI_1S;
            end else if (cmd_wr && wbyte_r == secondary_timer_pkg::CMD_PRI_500MS) begin
                pri_cnt_r <= PRI_500;
                pri_period_r <= PRI_500;
            end else if (cmd_wr && wbyte_r == secondary_timer_pkg::CMD_PRI_250MS) begin
                pri_cnt_r <= PRI_250;
                pri_period_r <= PRI_250;
            end else if (tick) begin
                // Other command values fall through here untouched.
                if (pri_cnt_r == '0) begin
                    pri_exp_r <= 1'b1;
                    pri_cnt_r <= pri_period_r;
                end else begin
                    pri_cnt_r <= pri_cnt_r - secondary_timer_pkg::PRI_W'(1);
                end
            end
        end
    end

    // ========================================================================
    // Interrupts: a new event wins over a clear in the same cycle.
    always_comb begin
        irq_set = '0;
        irq_set[secondary_timer_pkg::IRQ_SEC_BIT] = sec.expire;
        irq_set[secondary_timer_pkg::IRQ_PRI_BIT] = pri_exp_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_r <= '0;
        end else if (do_wr && wlane0_r && waddr_r == secondary_timer_pkg::OFF_IRQ_CLR) begin
            irq_stat_r <= (irq_stat_r & ~wbyte_r[secondary_timer_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_r <= secondary_timer_pkg::IRQ_EN_RESET;
        end else if (do_wr && wlane0_r && waddr_r == secondary_timer_pkg::OFF_IRQ_EN) begin
            irq_en_r <= wbyte_r[secondary_timer_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
            irq_priority <= 2'h0;
        end else begin
            irq_r <= |(irq_stat_r & irq_en_r);
            irq_priority <= secondary_timer_pkg::SEC_PRIORITY;
        end
    end

    // ========================================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_quiet_when_stopped;
        !sec.running |=> !sec.expire;
    endproperty
    a_quiet_when_stopped: assert property (p_quiet_when_stopped) else $error("Stopped timer expired.");

    property p_enable;
        (ctl.restart && !sec.running) |=> sec.running && sec.count == $past(sec.pend);
    endproperty
    a_enable: assert property (p_enable) else $error("Restart code did not start the timer.");

    property p_restart_no_irq;
        (ctl.restart && sec.running) |=> sec.count == sec.active ##1 !sec.expire;
    endproperty
    a_restart_no_irq: assert property (p_restart_no_irq) else $error("Restart did not reload the count.");

    property p_expire_irq;
        sec.expire |=> irq_stat_r[secondary_timer_pkg::IRQ_SEC_BIT] ##1 (irq_r == irq_en_r[secondary_timer_pkg::IRQ_SEC_BIT]) || irq_r;
    endproperty
    a_expire_irq: assert property (p_expire_irq) else $error("Expiry did not raise its status bit.");

    property p_pri_2s;
        (cmd_wr && wbyte_r == secondary_timer_pkg::CMD_PRI_2S) |=> pri_cnt_r == PRI_2S && pri_period_r == PRI_2S;
    endproperty
    a_pri_2s: assert property (p_pri_2s) else $error("Primary 2 s restart wrong.");

    property p_pri_250;
        (cmd_wr && wbyte_r == secondary_timer_pkg::CMD_PRI_250MS) |=> pri_cnt_r == PRI_250;
    endproperty
    a_pri_250: assert property (p_pri_250) else $error("Primary 250 ms restart wrong.");

    property p_other_code;
        (cmd_wr && wbyte_r != secondary_timer_pkg::CMD_SEC_RESTART && wbyte_r != secondary_timer_pkg::CMD_PRI_2S &&
         wbyte_r != secondary_timer_pkg::CMD_PRI_1S && wbyte_r != secondary_timer_pkg::CMD_PRI_500MS &&
         wbyte_r != secondary_timer_pkg::CMD_PRI_250MS) |=> $stable(pri_period_r) && $stable(sec.running);
    endproperty
    a_other_code: assert property (p_other_code) else $error("Unknown command changed a watchdog.");

    property p_stop_seq;
        seq_done |=> !sec.running ##1 !sec.running;
    endproperty
    a_stop_seq: assert property (p_stop_seq) else $error("Stop sequence did not stop the timer.");

    property p_seq_break;
        (tc_wr && seq_r == secondary_timer_pkg::SECONDARY_TIMER_SEQ_GOT1 && wbyte_r != secondary_timer_pkg::SEQ_BYTE2 &&
         wbyte_r != secondary_timer_pkg::SEQ_BYTE1) |=> seq_r == secondary_timer_pkg::SECONDARY_TIMER_SEQ_IDLE && sec.pend == $past(wbyte_r);
    endproperty
    a_seq_break: assert property (p_seq_break) else $error("Broken sequence not restarted.");

    c_expire: cover property (sec.expire ##[1:300] irq_r);
    c_stop: cover property (seq_done);
    c_restart: cover property (ctl.restart && sec.running);
    c_pri: cover property (pri_exp_r);

endmodule

// [verification/test_secondary_timer_top.sv]
// Self-checking bench for the secondary watchdog block.
// Assumes secondary_timer_pkg is compiled first and the shortened primary periods below.
`timescale 1ns/100ps
module test_secondary_timer_top;
    logic aclk, aresetn, ref_clk_in, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, primary_expired;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, irq_priority;
    int errors, comparisons, tick_n, div, t0, t1, t2;
    localparam int PT[4] = '{40, 30, 20, 10};
    localparam logic [7:0] PC[4] = '{8'h5A, 8'h57, 8'h59, 8'h53};

    secondary_timer_top #(.PRI_TICKS_2S(40), .PRI_TICKS_1S(30), .PRI_TICKS_500MS(20), .PRI_TICKS_250MS(10)) i_secondary_timer_top (
        .aclk(aclk), .aresetn(aresetn), .ref_clk_in(ref_clk_in), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
        .irq_priority(irq_priority), .primary_expired(primary_expired));

    // ========================================================================
    // Clocks and common tasks
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // The reference level toggles every five bus cycles, so a tick lands every ten.
    always @(posedge aclk) begin
        if (div == 4) begin
            div <= 0;
            ref_clk_in <= ~ref_clk_in;
            if (!ref_clk_in) tick_n <= tick_n + 1;
        end else div <= div + 1;
    end

    task summarize;
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task hang(input string name);
        errors++;
        $display("Error %s expected %h seen %h", name, 1, 0);
        summarize;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) hang("bvalid");
        bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task rd_reg(input logic [7:0] a, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) hang("rvalid");
        rready <= 1'b0;
        rd = rdata;
        check("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    task wait_irq(output int t);
        int n;
        for (n = 0; n < 600; n++) begin
            @(posedge aclk);
            if (irq === 1'b1) break;
        end
        if (n == 600) hang("irq");
        t = tick_n;
    endtask

    // ========================================================================
    // Scenarios
    task t_reset;
        check("irq", 32'h0, {31'h0, irq});
        rd_reg(secondary_timer_pkg::OFF_STATE, secondary_timer_pkg::RESP_OKAY);
        check("irq_priority", 32'h3, {30'h0, irq_priority});
        check("running", 32'h0, {31'h0, rd[16]});
        rd_reg(8'hFC, secondary_timer_pkg::RESP_SLVERR);
        wr(8'hF0, {24'h0, secondary_timer_pkg::CMD_SEC_RESTART}, secondary_timer_pkg::RESP_SLVERR);
        wr(secondary_timer_pkg::OFF_CMD, 32'h0000_00A5, secondary_timer_pkg::RESP_OKAY);
        rd_reg(secondary_timer_pkg::OFF_STATE, secondary_timer_pkg::RESP_OKAY);
        check("running", 32'h0, {31'h0, rd[16]});
    endtask

    task t_periodic;
        wr(secondary_timer_pkg::OFF_IRQ_EN, 32'h1, secondary_timer_pkg::RESP_OKAY);
        wr(secondary_timer_pkg::OFF_TCONST, 32'h3, secondary_timer_pkg::RESP_OKAY);
        wr(secondary_timer_pkg::OFF_CMD, {24'h0, secondary_timer_pkg::CMD_SEC_RESTART}, secondary_timer_pkg::RESP_OKAY);
        rd_reg(secondary_timer_pkg::OFF_STATE, secondary_timer_pkg::RESP_OKAY);
        check("run_active", 32'h10300, {15'h0, rd[16:0]} & 32'h1FF00);
        wait_irq(t0);
        check("irq_priority", 32'h3, {30'h0, irq_priority});
        wr(secondary_timer_pkg::OFF_IRQ_CLR, 32'h1, secondary_timer_pkg::RESP_OKAY);
        wr(secondary_timer_pkg::OFF_TCONST, 32'h7, secondary_timer_pkg::RESP_OKAY);
        wait_irq(t1);
        check("period", 32'h4, t1 - t0);
        wr(secondary_timer_pkg::OFF_IRQ_CLR, 32'h1, secondary_timer_pkg::RESP_OKAY);
        wait_irq(t2);
        check("period", 32'h8, t2 - t1);
        wr(secondary_timer_pkg::OFF_IRQ_CLR, 32'h1, secondary_timer_pkg::RESP_OKAY);
    endtask

    // Restarts come about every one and a half ticks, well inside the eight-tick period.
    task t_restart;
        repeat (8) begin
            wr(secondary_timer_pkg::OFF_CMD, {24'h0, secondary_timer_pkg::CMD_SEC_RESTART}, secondary_timer_pkg::RESP_OKAY);
            repeat (10) @(posedge aclk);
        end
        rd_reg(secondary_timer_pkg::OFF_IRQ_STAT, secondary_timer_pkg::RESP_OKAY);
        check("sec_status", 32'h0, {31'h0, rd[0]});
    endtask

    task t_sequence;
        wr(secondary_timer_pkg::OFF_TCONST, 32'h5A, secondary_timer_pkg::RESP_OKAY);
        wr(secondary_timer_pkg::OFF_TCONST, 32'h52, secondary_timer_pkg::RESP_OKAY);
        wr(secondary_timer_pkg::OFF_TCONST, 32'h10, secondary_timer_pkg::RESP_OKAY);
        wr(secondary_timer_pkg::OFF_TCONST, 32'h44, secondary_timer_pkg::RESP_OKAY);
        rd_reg(secondary_timer_pkg::OFF_STATE, secondary_timer_pkg::RESP_OKAY);
        check("run_held", 32'h4400_0001, {rd[31:24], 23'h0, rd[16]});
        wr(secondary_timer_pkg::OFF_TCONST, 32'h5A, secondary_timer_pkg::RESP_OKAY);
        wr(secondary_timer_pkg::OFF_TCONST, 32'h52, secondary_timer_pkg::RESP_OKAY);
        wr(secondary_timer_pkg::OFF_TCONST, 32'h44, secondary_timer_pkg::RESP_OKAY);
        wr(secondary_timer_pkg::OFF_IRQ_CLR, 32'h1, secondary_timer_pkg::RESP_OKAY);
        repeat (200) @(posedge aclk);
        rd_reg(secondary_timer_pkg::OFF_STATE, secondary_timer_pkg::RESP_OKAY);
        check("running", 32'h0, {31'h0, rd[16]});
        check("irq", 32'h0, {31'h0, irq});
    endtask

    // A tick of slack is allowed, since the restart write and the tick grid are not aligned.
    task t_primary;
        int n, i;
        for (i = 0; i < 4; i++) begin
            wr(secondary_timer_pkg::OFF_CMD, {24'h0, PC[i]}, secondary_timer_pkg::RESP_OKAY);
            t0 = tick_n;
            for (n = 0; n < 600; n++) begin
                @(posedge aclk);
                if (primary_expired === 1'b1) break;
            end
            if (n == 600) hang("primary_expired");
            check("primary_ticks", 32'h1, {31'h0, (tick_n - t0 >= PT[i] - 1) && (tick_n - t0 <= PT[i])});
        end
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        aresetn = 1'b0; ref_clk_in = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        wstrb = 4'hF; errors = 0; comparisons = 0; tick_n = 0; div = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_periodic;
        t_restart;
        t_sequence;
        t_primary;
        summarize;
    end
endmodule
